//--- rtl/ssw_top.sv
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Any supply below its trip level asserts the reset output.
// - After supplies recover, reset stays asserted for the hold period.
// - Reset output polarity is chosen at build time.
// - Watchdog expiry asserts reset for the full hold period.
// - Watchdog counter stays zero while reset is asserted.
// - Watchdog counter clears on reset or any kick input transition.
// - Kick pulses as narrow as 50 ns count as service.
// - Internal kick driver is low seven eighths, high the rest.
// - A floating kick input never lets the watchdog expire.
// - Manual reset low asserts reset, then hold period after release.
// - A bouncing manual switch still gives one clean reset sequence.
// - Supply dips up to 55 us are filtered out.
// - Manual reset glitches near 90 ns rejected, 1 us accepted.
module ssw_top
  import ssw_pkg::*;
#(
  parameter int unsigned HOLD_CYC = int'(HOLD_CYC_DEF),
  parameter int unsigned WD_CYC = int'(WD_CYC_DEF),
  parameter bit ACTIVE_HIGH = 1'b0
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic supply_low_in,
  input wire logic adjustable_sense_in,
  input wire logic manual_reset_in_n,
  input wire logic watchdog_kick_in,
  output logic watchdog_kick_out,
  output logic watchdog_kick_oe,
  output logic alt_polarity_reset_out
);

  localparam int HW = $clog2(HOLD_CYC + 1);
  localparam int WW = $clog2(WD_CYC + 1);
  localparam int unsigned WD_DRV = (WD_CYC / WD_DRV_DEN) * WD_DRV_NUM;
  localparam logic ASSERT_LVL = ACTIVE_HIGH;

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // Floating-pin loop needs a few cycles between driver rise and expiry
  if (HOLD_CYC < 2 || WD_CYC < 64) begin : g_bad_times
    $error("ssw_top: HOLD_CYC or WD_CYC too small");
  end
  if (MR_FILT_CYC > MR_ACCEPT_CYC || CLK_PERIOD_NS > KICK_MIN_NS) begin : g_bad_clock
    $error("ssw_top: clock too slow for input filtering");
  end

  logic [NUM_SUPPLY-1:0] supply_raw;
  logic [NUM_SUPPLY-1:0] supply_bad;
  logic mr_clean_n;
  logic kick_a;
  logic kick_b;
  logic kick_c;
  logic kick_edge;
  logic [WW-1:0] wd_count;
  logic wd_expire;
  logic [HW-1:0] hold_cnt;
  logic [HW-1:0] next_hold;
  logic cause;
  logic rst_active;

  assign supply_raw = {adjustable_sense_in, supply_low_in};

  // ----------------------------------------
  // Input filters
  // ----------------------------------------
  // dip filter per supply
  for (genvar i = 0; i < NUM_SUPPLY; i++) begin : g_supply
    ssw_filt_if sup_if ();
    assign sup_if.raw = supply_raw[i];
    assign supply_bad[i] = sup_if.clean;
    ssw_filter #(.CYC(DIP_FILT_CYC), .INIT(SUPPLY_INIT)) u_filt (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .io(sup_if.filt)
    );
  end

  // bounce absorbed by filter and hold restart
  // short glitches rejected, long lows taken
  ssw_filt_if mr_if ();
  assign mr_if.raw = manual_reset_in_n;
  assign mr_clean_n = mr_if.clean;
  ssw_filter #(.CYC(MR_FILT_CYC), .INIT(MR_INIT)) u_mr_filt (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .io(mr_if.filt)
  );

  // ----------------------------------------
  // Kick input
  // ----------------------------------------
  // one clock period is shorter than the narrowest pulse
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      kick_a <= 1'b0;
      kick_b <= 1'b0;
      kick_c <= 1'b0;
    end else begin
      kick_a <= watchdog_kick_in;
      kick_b <= kick_a;
      kick_c <= kick_b;
    end
  end

  assign kick_edge = kick_b ^ kick_c;

  // ----------------------------------------
  // Watchdog counter
  // ----------------------------------------
  // held at zero while reset asserted
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wd_count <= '0;
      wd_expire <= 1'b0;
    end else if (rst_active || kick_edge) begin
      wd_count <= '0;
      wd_expire <= 1'b0;
    end else if (wd_count == WW'(WD_CYC - 1)) begin
      wd_count <= '0;
      wd_expire <= 1'b1;
    end else begin
      wd_count <= wd_count + WW'(1);
      wd_expire <= 1'b0;
    end
  end

  // ----------------------------------------
  // Internal kick driver
  // ----------------------------------------
  // high only in the last eighth of the period
  // a floating pin follows this driver and clears the counter
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      watchdog_kick_out <= 1'b0;
      watchdog_kick_oe <= 1'b1;
    end else begin
      watchdog_kick_out <= (wd_count >= WW'(WD_DRV));
      watchdog_kick_oe <= 1'b1;
    end
  end

  // ----------------------------------------
  // Reset causes and hold timer
  // ----------------------------------------
  // supply fault, manual reset or watchdog expiry
  assign cause = (|supply_bad) | ~mr_clean_n | wd_expire;

  // reload while any cause present, count down after
  always_comb begin
    if (cause) begin
      next_hold = HW'(HOLD_CYC);
    end else if (hold_cnt != '0) begin
      next_hold = hold_cnt - HW'(1);
    end else begin
      next_hold = '0;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      hold_cnt <= HW'(HOLD_CYC);
      rst_active <= 1'b1;
    end else begin
      hold_cnt <= next_hold;
      rst_active <= (next_hold != '0);
    end
  end

  // polarity applied at the output flop
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      alt_polarity_reset_out <= ASSERT_LVL;
    end else begin
      alt_polarity_reset_out <= (next_hold != '0) ? ASSERT_LVL : ~ASSERT_LVL;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_supply_rst;
    @(posedge clk_sys) disable iff (sys_rst)
    (|supply_bad) |=> (rst_active && alt_polarity_reset_out == ASSERT_LVL);
  endproperty
  a_supply_rst: assert property (p_supply_rst) else $error("supply fault did not assert reset");

  property p_hold_start;
    @(posedge clk_sys) disable iff (sys_rst)
    $fell(cause) |=> (hold_cnt == HW'(HOLD_CYC - 1) && rst_active);
  endproperty
  a_hold_start: assert property (p_hold_start) else $error("hold period did not start");

  property p_release;
    @(posedge clk_sys) disable iff (sys_rst)
    (hold_cnt == HW'(1) && !cause) |=> (!rst_active ##1 !rst_active || cause);
  endproperty
  a_release: assert property (p_release) else $error("reset not released after hold");

  property p_polarity;
    @(posedge clk_sys) disable iff (sys_rst)
    (alt_polarity_reset_out == ASSERT_LVL) == rst_active;
  endproperty
  a_polarity: assert property (p_polarity) else $error("output level disagrees with reset state");

  property p_wd_full;
    @(posedge clk_sys) disable iff (sys_rst)
    wd_expire |=> (hold_cnt == HW'(HOLD_CYC) && rst_active);
  endproperty
  a_wd_full: assert property (p_wd_full) else $error("watchdog expiry did not load hold");

  property p_wd_frozen;
    @(posedge clk_sys) disable iff (sys_rst)
    rst_active |=> (wd_count == '0);
  endproperty
  a_wd_frozen: assert property (p_wd_frozen) else $error("watchdog advanced during reset");

  property p_kick_clear;
    @(posedge clk_sys) disable iff (sys_rst)
    (kick_edge && !rst_active) |=> (wd_count == '0 && !wd_expire);
  endproperty
  a_kick_clear: assert property (p_kick_clear) else $error("kick edge did not clear watchdog");

  property p_drv_low;
    @(posedge clk_sys) disable iff (sys_rst)
    (wd_count < WW'(WD_DRV)) |=> !watchdog_kick_out;
  endproperty
  a_drv_low: assert property (p_drv_low) else $error("kick driver high too early");

  property p_mr_rst;
    @(posedge clk_sys) disable iff (sys_rst)
    $rose(mr_clean_n) |-> (rst_active ##1 rst_active);
  endproperty
  a_mr_rst: assert property (p_mr_rst) else $error("manual reset release ended reset early");

endmodule

`default_nettype wire

//--- rtl/ssw_pkg.sv
`default_nettype none

package ssw_pkg;

  // ----------------------------------------
  // Clock
  // ----------------------------------------
  localparam longint CLK_HZ = 64'd25_000_000;
  localparam longint CLK_PERIOD_NS = 64'd40;

  // ----------------------------------------
  // Reset hold period (least time, rounds up)
  // ----------------------------------------
  localparam longint HOLD_MS = 64'd140;
  localparam longint HOLD_CYC_DEF = (HOLD_MS * CLK_HZ + 64'd999) / 64'd1000;

  // ----------------------------------------
  // Watchdog timeout and internal kick driver
  // ----------------------------------------
  localparam longint WD_MS = 64'd1500;
  localparam longint WD_CYC_DEF = (WD_MS * CLK_HZ) / 64'd1000;
  localparam int WD_DRV_NUM = 7;
  localparam int WD_DRV_DEN = 8;
  localparam longint KICK_MIN_NS = 64'd50;

  // ----------------------------------------
  // Input filters
  // ----------------------------------------
  localparam int NUM_SUPPLY = 2;
  localparam longint DIP_US = 64'd55;
  localparam int DIP_FILT_CYC = int'((DIP_US * CLK_HZ) / 64'd1_000_000) + 1;
  localparam longint MR_GLITCH_NS = 64'd90;
  localparam int MR_FILT_CYC = int'((MR_GLITCH_NS * CLK_HZ + 64'd999_999_999) / 64'd1_000_000_000) + 1;
  localparam longint MR_ACCEPT_NS = 64'd1000;
  localparam int MR_ACCEPT_CYC = int'((MR_ACCEPT_NS * CLK_HZ) / 64'd1_000_000_000);

  // ----------------------------------------
  // Filter reset levels
  // ----------------------------------------
  localparam logic SUPPLY_INIT = 1'b1;
  localparam logic MR_INIT = 1'b1;

endpackage

`default_nettype wire

//--- rtl/ssw_filt_if.sv
`timescale 1ns/100ps
`default_nettype none

// Raw pin level in, settled level out
interface ssw_filt_if;
  logic raw;
  logic clean;
  modport user (output raw, input clean);
  modport filt (input raw, output clean);
endinterface

`default_nettype wire

//--- rtl/ssw_filter.sv
`timescale 1ns/100ps
`default_nettype none

module ssw_filter
  import ssw_pkg::*;
#(
  parameter int CYC = 4,
  parameter logic INIT = 1'b1
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  ssw_filt_if.filt io
);

  localparam int CW = $clog2(CYC + 1);

  // Refuse a filter length the counter cannot serve
  if (CYC < 1) begin : g_bad_cyc
    $error("ssw_filter: CYC must be at least 1");
  end

  logic sync_a;
  logic sync_b;
  logic [CW-1:0] cnt;

  // ----------------------------------------
  // Synchroniser
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sync_a <= INIT;
      sync_b <= INIT;
    end else begin
      sync_a <= io.raw;
      sync_b <= sync_a;
    end
  end

  // ----------------------------------------
  // Stability counter
  // ----------------------------------------
  // Level must differ for CYC cycles in a row before it is taken
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= '0;
      io.clean <= INIT;
    end else if (sync_b == io.clean) begin
      cnt <= '0;
    end else if (cnt == CW'(CYC - 1)) begin
      cnt <= '0;
      io.clean <= sync_b;
    end else begin
      cnt <= cnt + CW'(1);
    end
  end

  property p_filt_take;
    @(posedge clk_sys) disable iff (sys_rst)
    (sync_b != io.clean && cnt == CW'(CYC - 1)) |=> (io.clean == $past(sync_b));
  endproperty
  a_filt_take: assert property (p_filt_take) else $error("filter did not take settled level");

  property p_filt_hold;
    @(posedge clk_sys) disable iff (sys_rst)
    (cnt < CW'(CYC - 1)) |=> $stable(io.clean);
  endproperty
  a_filt_hold: assert property (p_filt_hold) else $error("filter output moved too early");

endmodule

`default_nettype wire

//--- bench/ssw_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none

// Processor side: services the watchdog kick line
module ssw_cpu_model (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic reset_active,
  input wire logic [15:0] kick_gap,
  output logic kick_drv,
  output logic kick_drv_en
);
  logic [15:0] gap_cnt;

  // Low most of the gap, two-cycle high pulse at its end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      gap_cnt <= 16'h0000;
      kick_drv <= 1'b0;
    end else if (reset_active || gap_cnt >= kick_gap) begin
      gap_cnt <= 16'h0000;
      kick_drv <= 1'b0;
    end else begin
      gap_cnt <= gap_cnt + 16'h0001;
      kick_drv <= ({1'b0, gap_cnt} + 17'h00002 >= {1'b0, kick_gap});
    end
  end

  // Gap of zero leaves the pin undriven
  assign kick_drv_en = (kick_gap != 16'h0000);
endmodule

`default_nettype wire

//--- bench/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import ssw_pkg::*;
  localparam int HOLD = 50;
  localparam int WD = 400;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic supply_low_in = 1'b0;
  logic adjustable_sense_in = 1'b0;
  logic manual_reset_in_n = 1'b1;
  logic [15:0] kick_gap = 16'h0000;
  logic kick_drv, kick_drv_en, kick_out, kick_oe, rst_out, rst_out_hi;
  logic kick_wire, asserted;
  int n_mismatch = 0;
  int checks_done = 0;
  int n;

  // Clock and wire resolution; external driver wins
  always #20 clk_sys = ~clk_sys;
  assign kick_wire = kick_drv_en ? kick_drv : (kick_oe ? kick_out : ~kick_out);
  assign asserted = ~rst_out;

  ssw_top #(.HOLD_CYC(HOLD), .WD_CYC(WD), .ACTIVE_HIGH(1'b0)) u_ssw_top (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .supply_low_in(supply_low_in), .adjustable_sense_in(adjustable_sense_in),
    .manual_reset_in_n(manual_reset_in_n), .watchdog_kick_in(kick_wire), .watchdog_kick_out(kick_out),
    .watchdog_kick_oe(kick_oe), .alt_polarity_reset_out(rst_out));
  ssw_top #(.HOLD_CYC(HOLD), .WD_CYC(WD), .ACTIVE_HIGH(1'b1)) u_ssw_top_hi (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .supply_low_in(supply_low_in), .adjustable_sense_in(adjustable_sense_in),
    .manual_reset_in_n(manual_reset_in_n), .watchdog_kick_in(kick_wire), .watchdog_kick_out(),
    .watchdog_kick_oe(), .alt_polarity_reset_out(rst_out_hi));
  ssw_cpu_model u_ssw_cpu_model (.clk_sys(clk_sys), .sys_rst(sys_rst), .reset_active(asserted),
    .kick_gap(kick_gap), .kick_drv(kick_drv), .kick_drv_en(kick_drv_en));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic wrap_up;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rng(input int lo, input int hi);
    chk({31'h0, (n >= lo && n <= hi)}, 32'h1);
  endtask

  // Bounded wait for reset (or kick driver) to reach a level
  task automatic wait_lvl(input bit on_kick, input logic lvl, input int max);
    n = 0;
    while ((on_kick ? kick_out : asserted) !== lvl) begin
      @(posedge clk_sys);
      #1;
      n++;
      if (n > max) begin
        chk(32'h0, 32'h1);
        wrap_up();
      end
    end
  endtask

  // No reset for a span; both polarities agree
  task automatic quiet(input int cyc);
    logic bad;
    bad = 1'b0;
    repeat (cyc) begin
      @(posedge clk_sys);
      #1;
      if (asserted !== 1'b0) bad = 1'b1;
    end
    chk(bad, 1'b0);
    chk(rst_out_hi, asserted);
  endtask

  task automatic set_sup(input int k, input logic v);
    @(posedge clk_sys);
    if (k == 0) supply_low_in <= v;
    else adjustable_sense_in <= v;
  endtask

  task automatic set_mr(input logic v, input int cyc);
    @(posedge clk_sys);
    manual_reset_in_n <= v;
    repeat (cyc) @(posedge clk_sys);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_power_on;
    repeat (10) @(posedge clk_sys);
    chk(rst_out, 1'b0);
    sys_rst <= 1'b0;
    // Supply filters start at the fault level, so filter time comes first
    wait_lvl(0, 1'b0, HOLD + 1400);
    rng(HOLD + 1376, HOLD + 1386);
  endtask

  task automatic t_supply;
    for (int k = 0; k < 2; k++) begin
      set_sup(k, 1'b1);
      repeat (1300) @(posedge clk_sys);
      set_sup(k, 1'b0);
      quiet(1500);
      set_sup(k, 1'b1);
      wait_lvl(0, 1'b1, 1400);
      rng(1376, 1384);
      repeat (200) @(posedge clk_sys);
      chk(asserted, 1'b1);
      chk(rst_out_hi, 1'b1);
      set_sup(k, 1'b0);
      wait_lvl(0, 1'b0, HOLD + 1400);
      rng(HOLD + 1376, HOLD + 1386);
    end
  endtask

  task automatic t_manual;
    set_mr(1'b0, 2);
    set_mr(1'b1, 0);
    quiet(40);
    set_mr(1'b0, 0);
    wait_lvl(0, 1'b1, 12);
    rng(4, 10);
    repeat (30) @(posedge clk_sys);
    for (int i = 0; i < 3; i++) begin
      set_mr(1'b1, 2);
      set_mr(1'b0, 2);
    end
    set_mr(1'b1, 8);
    set_mr(1'b0, 20);
    chk(asserted, 1'b1);
    set_mr(1'b1, 0);
    wait_lvl(0, 1'b0, HOLD + 20);
    rng(HOLD + 4, HOLD + 10);
  endtask

  task automatic t_watchdog;
    @(posedge clk_sys);
    kick_gap <= 16'd200;
    quiet(3 * WD);
    @(posedge clk_sys);
    kick_gap <= 16'hffff;
    wait_lvl(0, 1'b1, WD + 20);
    wait_lvl(0, 1'b0, HOLD + 5);
    rng(HOLD, HOLD + 2);
    wait_lvl(0, 1'b1, WD + 20);
    rng(WD - 2, WD + 4);
    @(posedge clk_sys);
    kick_gap <= 16'h0000;
    wait_lvl(0, 1'b0, HOLD + 5);
  endtask

  task automatic t_float;
    quiet(3 * WD);
    wait_lvl(1, 1'b1, 2 * WD);
    wait_lvl(1, 1'b0, 20);
    wait_lvl(1, 1'b1, WD);
    // Low time adds the sync and edge latency of the self-clearing loop
    rng(WD / 8 * 7 + 2, WD / 8 * 7 + 6);
    chk(kick_oe, 1'b1);
  endtask

  // Main sequence
  initial begin
    t_power_on();
    t_supply();
    t_manual();
    t_watchdog();
    t_float();
    wrap_up();
  end
endmodule

`default_nettype wire
